// file: verilog/vector_table_pkg.sv
// ****************************************************************
// constants shared by both ends
// ****************************************************************
package vector_table_pkg;
   localparam int NUM_VEC = 32;
   localparam int VEC_W = 5;
   localparam int LVL_W = 3;
   localparam int ADDR_W = 24;
   localparam int REG_W = 16;
   localparam int SLOT_SHIFT = 2;
   localparam int BASE_ALIGN_BITS = 8;
   localparam logic [ADDR_W-1:0] BASE_RESET = 24'h008000;
   localparam logic [REG_W-1:0] PROTECT_KEY = 16'h0096;
   localparam logic [LVL_W-1:0] LEVEL_RESET = 3'h0;
   // hardware vector numbers
   localparam int VEC_PWM0 = 14;
   localparam int VEC_PWM1 = 15;
   localparam int VEC_UART1 = 16;
   localparam int VEC_SOUND = 17;
   localparam int VEC_IR = 18;
   localparam int VEC_LCD = 19;
   localparam int VEC_RFC0 = 20;
   localparam int VEC_RFC1 = 21;
   localparam int VEC_TMR2 = 22;
   localparam int VEC_SPI1 = 23;
   localparam int VEC_TMR3 = 24;
   localparam int VEC_ADC = 25;
   localparam int VEC_PWM2 = 26;
   localparam int VEC_RSV_FIRST = 27;
   // cause widths per source
   localparam int PWM_CAUSES = 4;
   localparam int UART_CAUSES = 7;
   localparam int RFC_CAUSES = 5;
   localparam int SPI_CAUSES = 4;
   localparam int ADC_CAUSES = 2;
   localparam int SOUND_CAUSES = 2;
endpackage

// file: verilog/vector_link_if.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// request link between controller and cpu core
// ****************************************************************
interface vector_link_if;
   import vector_table_pkg::*;
   logic irq;
   logic [LVL_W-1:0] irq_level;
   logic [VEC_W-1:0] irq_vector;
   logic [ADDR_W-1:0] vector_addr;
   logic ack;

   modport ctrl (output irq, output irq_level, output irq_vector, output vector_addr,
                 input ack);
   modport cpu (input irq, input irq_level, input irq_vector, input vector_addr,
                output ack);
endinterface
`default_nettype wire

// file: verilog/vector_address_calc.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// slot address: base plus four bytes per vector
// ****************************************************************
module vector_address_calc (
   // operands
   input wire logic [vector_table_pkg::ADDR_W-1:0] base_in,
   input wire logic [vector_table_pkg::VEC_W-1:0] vector_in,
   // result
   output logic [vector_table_pkg::ADDR_W-1:0] addr_out
);
   import vector_table_pkg::*;
   logic [ADDR_W-1:0] offset;

   always_comb begin
      offset = ADDR_W'({vector_in, 2'b00});
      addr_out = base_in + offset;
   end
endmodule // vector_address_calc
`default_nettype wire

// file: verilog/interrupt_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
module interrupt_arbiter (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   // peripheral causes, flag already gated by its enable
   input wire logic [vector_table_pkg::PWM_CAUSES-1:0] pwm0_cause_in,
   input wire logic [vector_table_pkg::PWM_CAUSES-1:0] pwm1_cause_in,
   input wire logic [vector_table_pkg::PWM_CAUSES-1:0] pwm2_cause_in,
   input wire logic [vector_table_pkg::UART_CAUSES-1:0] uart1_cause_in,
   input wire logic [vector_table_pkg::SOUND_CAUSES-1:0] sound_cause_in,
   input wire logic ir_cause_in,
   input wire logic lcd_frame_in,
   input wire logic [vector_table_pkg::RFC_CAUSES-1:0] rfc0_cause_in,
   input wire logic [vector_table_pkg::RFC_CAUSES-1:0] rfc1_cause_in,
   input wire logic tmr2_underflow_in,
   input wire logic tmr3_underflow_in,
   input wire logic [vector_table_pkg::SPI_CAUSES-1:0] spi1_cause_in,
   input wire logic [vector_table_pkg::ADC_CAUSES-1:0] adc_cause_in,
   // protection and base register writes
   input wire logic protect_wr_in,
   input wire logic [vector_table_pkg::REG_W-1:0] system_protect_key_in,
   input wire logic base_low_wr_in,
   input wire logic base_high_wr_in,
   input wire logic [vector_table_pkg::REG_W-1:0] base_data_in,
   // level setting writes
   input wire logic level_wr_in,
   input wire logic [vector_table_pkg::VEC_W-1:0] level_sel_in,
   input wire logic [vector_table_pkg::LVL_W-1:0] source_interrupt_level_in,
   // readback
   output logic [vector_table_pkg::REG_W-1:0] vector_base_low_reg_out,
   output logic [vector_table_pkg::REG_W-1:0] vector_base_high_reg_out,
   output logic protect_lifted_out,
   // cpu link
   vector_link_if.ctrl link
);
   import vector_table_pkg::*;

   // ****************************************************************
   // cause mapping
   // ****************************************************************
   logic [NUM_VEC-1:0] raw_req;

   always_comb begin
      raw_req = '0;
      raw_req[VEC_PWM0] = |pwm0_cause_in;
      raw_req[VEC_PWM1] = |pwm1_cause_in;
      raw_req[VEC_PWM2] = |pwm2_cause_in;
      raw_req[VEC_UART1] = |uart1_cause_in;
      raw_req[VEC_SOUND] = |sound_cause_in;
      raw_req[VEC_IR] = ir_cause_in;
      raw_req[VEC_LCD] = lcd_frame_in;
      // completions and the two overflow errors share one vector
      raw_req[VEC_RFC0] = |rfc0_cause_in;
      raw_req[VEC_RFC1] = |rfc1_cause_in;
      raw_req[VEC_TMR2] = tmr2_underflow_in;
      raw_req[VEC_TMR3] = tmr3_underflow_in;
      raw_req[VEC_SPI1] = |spi1_cause_in;
      raw_req[VEC_ADC] = |adc_cause_in;
   end

   // ****************************************************************
   // protection and table base
   // ****************************************************************
   logic unlocked;
   logic next_unlocked;
   logic [ADDR_W-1:BASE_ALIGN_BITS] base_hi;
   logic [ADDR_W-1:BASE_ALIGN_BITS] next_base_hi;
   logic [ADDR_W-1:0] next_base;

   always_comb begin
      next_unlocked = unlocked;
      next_base_hi = base_hi;
      if (protect_wr_in) begin
         next_unlocked = (system_protect_key_in == PROTECT_KEY);
      end
      if (unlocked && base_low_wr_in) begin
         next_base_hi[REG_W-1:BASE_ALIGN_BITS] = base_data_in[REG_W-1:BASE_ALIGN_BITS];
      end
      if (unlocked && base_high_wr_in) begin
         next_base_hi[ADDR_W-1:REG_W] = base_data_in[ADDR_W-REG_W-1:0];
      end
      next_base = {next_base_hi, {BASE_ALIGN_BITS{1'b0}}};
   end

   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         unlocked <= 1'b0;
         base_hi <= BASE_RESET[ADDR_W-1:BASE_ALIGN_BITS];
      end else begin
         unlocked <= next_unlocked;
         base_hi <= next_base_hi;
      end
   end

   // ****************************************************************
   // level table and accepted sources
   // ****************************************************************
   logic [LVL_W-1:0] level_tab [NUM_VEC];
   logic [LVL_W-1:0] next_level_tab [NUM_VEC];
   logic [NUM_VEC-1:0] taken;
   logic [NUM_VEC-1:0] next_taken;
   logic [NUM_VEC-1:0] eligible;
   // what the cpu sampled at its accepting edge; its ack comes one edge later,
   // when the shown vector may already have been replaced by a newer winner
   logic seen_irq;
   logic [VEC_W-1:0] seen_vec;

   always_comb begin
      for (int v = 0; v < NUM_VEC; v++) begin
         next_level_tab[v] = level_tab[v];
         if (level_wr_in && (level_sel_in == VEC_W'(v))) begin
            next_level_tab[v] = source_interrupt_level_in;
         end
         // accepted source stays out of the race until its flag drops;
         // an acceptance in the drop cycle still wins
         next_taken[v] = taken[v] & raw_req[v];
         if (link.ack && seen_irq && (seen_vec == VEC_W'(v))) begin
            next_taken[v] = 1'b1;
         end
         eligible[v] = raw_req[v] && !taken[v] && (level_tab[v] != LEVEL_RESET);
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         for (int v = 0; v < NUM_VEC; v++) begin
            level_tab[v] <= LEVEL_RESET;
         end
         taken <= '0;
      end else begin
         level_tab <= next_level_tab;
         taken <= next_taken;
      end
   end

   // ****************************************************************
   // arbitration
   // ****************************************************************
   logic found;
   logic [LVL_W-1:0] best_lvl;
   logic [VEC_W-1:0] best_vec;
   logic [ADDR_W-1:0] best_addr;

   // walk downward so that on equal level the smaller number wins
   always_comb begin
      found = 1'b0;
      best_lvl = LEVEL_RESET;
      best_vec = '0;
      for (int v = NUM_VEC-1; v >= 0; v--) begin
         if (eligible[v] && (!found || (level_tab[v] >= best_lvl))) begin
            found = 1'b1;
            best_lvl = level_tab[v];
            best_vec = VEC_W'(v);
         end
      end
   end

   vector_address_calc vector_address_calc_inst (
      .base_in(next_base),
      .vector_in(best_vec),
      .addr_out(best_addr)
   );

   // ****************************************************************
   // outputs
   // ****************************************************************
   logic irq_q;
   logic [LVL_W-1:0] lvl_q;
   logic [VEC_W-1:0] vec_q;
   logic [ADDR_W-1:0] addr_q;
   logic next_irq;
   logic [LVL_W-1:0] next_lvl;
   logic [VEC_W-1:0] next_vec;
   logic [ADDR_W-1:0] next_addr;

   // a newer higher-priority cause replaces the shown one while unaccepted
   always_comb begin
      next_irq = found;
      next_lvl = found ? best_lvl : LEVEL_RESET;
      next_vec = best_vec;
      next_addr = best_addr;
      if (link.ack && seen_irq && (best_vec == seen_vec)) begin
         next_irq = 1'b0;
         next_lvl = LEVEL_RESET;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         irq_q <= 1'b0;
         lvl_q <= LEVEL_RESET;
         vec_q <= '0;
         addr_q <= BASE_RESET;
         vector_base_low_reg_out <= BASE_RESET[REG_W-1:0];
         vector_base_high_reg_out <= REG_W'(BASE_RESET[ADDR_W-1:REG_W]);
         protect_lifted_out <= 1'b0;
         seen_irq <= 1'b0;
         seen_vec <= '0;
      end else begin
         irq_q <= next_irq;
         lvl_q <= next_lvl;
         vec_q <= next_vec;
         addr_q <= next_addr;
         vector_base_low_reg_out <= next_base[REG_W-1:0];
         vector_base_high_reg_out <= REG_W'(next_base[ADDR_W-1:REG_W]);
         protect_lifted_out <= next_unlocked;
         seen_irq <= irq_q;
         seen_vec <= vec_q;
      end
   end

   assign link.irq = irq_q;
   assign link.irq_level = lvl_q;
   assign link.irq_vector = vec_q;
   assign link.vector_addr = addr_q;
endmodule // interrupt_arbiter
`default_nettype wire

// file: verilog/cpu_vector_fetch.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// cpu side: acceptance and handler entry
// ****************************************************************
module cpu_vector_fetch (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   // instruction events
   input wire logic cpu_irq_enable_instr_in,
   input wire logic cpu_irq_disable_instr_in,
   input wire logic return_instr_in,
   // handler entry
   output logic enter_out,
   output logic [vector_table_pkg::ADDR_W-1:0] handler_addr_out,
   output logic [vector_table_pkg::VEC_W-1:0] handler_vector_out,
   output logic ie_out,
   output logic [vector_table_pkg::LVL_W-1:0] il_out,
   // link
   vector_link_if.cpu link
);
   import vector_table_pkg::*;

   typedef enum logic [1:0] {
      ST_RUN = 2'b01,
      ST_ENTER = 2'b10
   } cpu_state_t;

   cpu_state_t state;
   cpu_state_t next_state;
   logic ie;
   logic next_ie;
   logic [LVL_W-1:0] il;
   logic [LVL_W-1:0] next_il;
   logic saved_ie;
   logic next_saved_ie;
   logic [LVL_W-1:0] saved_il;
   logic [LVL_W-1:0] next_saved_il;
   logic ack_q;
   logic next_ack;
   logic [ADDR_W-1:0] addr_q;
   logic [ADDR_W-1:0] next_addr;
   logic [VEC_W-1:0] vec_q;
   logic [VEC_W-1:0] next_vec;
   logic accept;

   // ****************************************************************
   // acceptance: enabled and level above current
   // ****************************************************************
   always_comb begin
      // level zero can never exceed il, so it is never taken
      accept = (state == ST_RUN) && ie && link.irq && (link.irq_level > il);
      next_state = state;
      next_ie = ie;
      next_il = il;
      next_saved_ie = saved_ie;
      next_saved_il = saved_il;
      next_ack = 1'b0;
      next_addr = addr_q;
      next_vec = vec_q;
      case (state)
         ST_RUN: begin
            if (accept) begin
               next_ack = 1'b1;
               next_saved_ie = ie;
               next_saved_il = il;
               next_ie = 1'b0;
               next_il = link.irq_level;
               next_addr = link.vector_addr;
               next_vec = link.irq_vector;
               next_state = ST_ENTER;
            end else if (return_instr_in) begin
               next_ie = saved_ie;
               next_il = saved_il;
            end else if (cpu_irq_disable_instr_in) begin
               next_ie = 1'b0;
            end else if (cpu_irq_enable_instr_in) begin
               next_ie = 1'b1;
            end
         end
         ST_ENTER: begin
            next_state = ST_RUN;
         end
         default: begin
            next_state = ST_RUN;
         end
      endcase
   end

   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         state <= ST_RUN;
         ie <= 1'b0;
         il <= LEVEL_RESET;
         saved_ie <= 1'b0;
         saved_il <= LEVEL_RESET;
         ack_q <= 1'b0;
         addr_q <= BASE_RESET;
         vec_q <= '0;
      end else begin
         state <= next_state;
         ie <= next_ie;
         il <= next_il;
         saved_ie <= next_saved_ie;
         saved_il <= next_saved_il;
         ack_q <= next_ack;
         addr_q <= next_addr;
         vec_q <= next_vec;
      end
   end

   assign link.ack = ack_q;
   assign enter_out = ack_q;
   assign handler_addr_out = addr_q;
   assign handler_vector_out = vec_q;
   assign ie_out = ie;
   assign il_out = il;
endmodule // cpu_vector_fetch
`default_nettype wire

// file: tb/vector_table_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// link checks between controller and cpu
// ****************************************************************
module vector_table_asserts (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   // link signals
   input wire logic irq,
   input wire logic [vector_table_pkg::LVL_W-1:0] irq_level,
   input wire logic [vector_table_pkg::VEC_W-1:0] irq_vector,
   input wire logic [vector_table_pkg::ADDR_W-1:0] vector_addr,
   input wire logic ack
);
   import vector_table_pkg::*;
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!reset_n_in);
   // base is 256-byte aligned, so the low byte is the slot offset alone
   slot_addr_a: assert property (irq |-> vector_addr[7:0] == {1'b0, irq_vector, 2'b00})
      else $error("slot offset differs from four times the vector");
   low_vec_a: assert property (irq |-> irq_vector >= 5'h0e)
      else $error("request below the peripheral vectors");
   rsv_vec_a: assert property (irq |-> irq_vector <= 5'h1a)
      else $error("reserved vector raised");
   lvl_zero_a: assert property (irq |-> irq_level != 3'h0)
      else $error("request raised at level zero");
   reset_base_a: assert property ($rose(reset_n_in) |-> vector_addr == 24'h008000 && !irq)
      else $error("link not idle at default base after reset");
   ack_cause_a: assert property (ack |-> $past(irq))
      else $error("acknowledge without a request");
   ack_pulse_a: assert property (ack |=> !ack)
      else $error("acknowledge longer than one cycle");
   ack_clear_a: assert property (ack && $stable(irq_vector) |=>
      !irq || irq_vector != $past(irq_vector))
      else $error("accepted vector still presented");
endmodule // vector_table_asserts
`default_nettype wire

// file: tb/interrupt_vector_table_base_tb.sv
`timescale 1ns/1ps
`default_nettype none
module interrupt_vector_table_base_tb;
   import vector_table_pkg::*;
   // ****************************************************************
   // stimulus and observed signals
   // ****************************************************************
   logic ref_clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic [40:0] src = '0;
   logic prot_wr = 1'b0, low_wr = 1'b0, high_wr = 1'b0, lvl_wr = 1'b0;
   logic en_i = 1'b0, dis_i = 1'b0, ret_i = 1'b0;
   logic [15:0] key = '0, bdata = '0;
   logic [4:0] lsel = '0;
   logic [2:0] lval = '0;
   logic [15:0] low_rb, high_rb;
   logic lifted, enter, ie;
   logic [23:0] haddr;
   logic [4:0] hvec;
   logic [2:0] il;
   logic [23:0] base = 24'h008000;
   int failures = 0;
   int n_tests = 0;
   // cause slice of each source in src, vectors 14 to 26 in order
   localparam int LSB [13] = '{0, 4, 8, 15, 17, 18, 19, 24, 29, 30, 34, 35, 37};
   localparam int WID [13] = '{4, 4, 7, 2, 1, 1, 5, 5, 1, 4, 1, 2, 4};

   always #2.5 ref_clk_in = ~ref_clk_in;

   vector_link_if vector_link_if_inst ();
   interrupt_arbiter interrupt_arbiter_inst (
      .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
      .pwm0_cause_in(src[3:0]), .pwm1_cause_in(src[7:4]), .uart1_cause_in(src[14:8]),
      .sound_cause_in(src[16:15]), .ir_cause_in(src[17]), .lcd_frame_in(src[18]),
      .rfc0_cause_in(src[23:19]), .rfc1_cause_in(src[28:24]), .tmr2_underflow_in(src[29]),
      .spi1_cause_in(src[33:30]), .tmr3_underflow_in(src[34]), .adc_cause_in(src[36:35]),
      .pwm2_cause_in(src[40:37]), .protect_wr_in(prot_wr), .system_protect_key_in(key),
      .base_low_wr_in(low_wr), .base_high_wr_in(high_wr), .base_data_in(bdata),
      .level_wr_in(lvl_wr), .level_sel_in(lsel), .source_interrupt_level_in(lval),
      .vector_base_low_reg_out(low_rb), .vector_base_high_reg_out(high_rb),
      .protect_lifted_out(lifted), .link(vector_link_if_inst));
   cpu_vector_fetch cpu_vector_fetch_inst (
      .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .cpu_irq_enable_instr_in(en_i),
      .cpu_irq_disable_instr_in(dis_i), .return_instr_in(ret_i), .enter_out(enter),
      .handler_addr_out(haddr), .handler_vector_out(hvec), .ie_out(ie), .il_out(il),
      .link(vector_link_if_inst));
   vector_table_asserts vector_table_asserts_inst (
      .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .irq(vector_link_if_inst.irq),
      .irq_level(vector_link_if_inst.irq_level), .irq_vector(vector_link_if_inst.irq_vector),
      .vector_addr(vector_link_if_inst.vector_addr), .ack(vector_link_if_inst.ack));

   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task automatic tick(int n = 1);
      repeat (n) begin
         @(posedge ref_clk_in);
         #1;
      end
   endtask
   task automatic check(logic [23:0] seen, logic [23:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // trailing idle cycle keeps a strobe from being raised twice in one step
   task automatic pulse(ref logic s);
      s = 1'b1;
      tick();
      s = 1'b0;
      tick();
   endtask
   task automatic set_key(logic [15:0] k);
      key = k;
      pulse(prot_wr);
   endtask
   task automatic wbase(bit hi, logic [15:0] d);
      bdata = d;
      if (hi) pulse(high_wr);
      else pulse(low_wr);
   endtask
   task automatic set_lvl(int v, int l);
      lsel = v[4:0];
      lval = l[2:0];
      pulse(lvl_wr);
   endtask
   task automatic see_irq(logic on, int v, int l);
      check(24'(vector_link_if_inst.irq), 24'(on));
      if (on) begin
         check(24'(vector_link_if_inst.irq_vector), 24'(v));
         check(24'(vector_link_if_inst.irq_level), 24'(l));
         check(vector_link_if_inst.vector_addr, base + 24'(4 * v));
      end
   endtask
   task automatic accept(int v, int l);
      int k = 0;
      while (enter !== 1'b1 && k < 20) begin
         tick();
         k++;
      end
      check(24'(enter), 24'h1);
      check(haddr, base + 24'(4 * v));
      check(24'(hvec), 24'(v));
      check(24'(il), 24'(l));
      // the cpu ignores instruction pulses while it is entering a handler
      tick();
   endtask

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_reset();
      check(24'(low_rb), 24'h008000);
      check(24'(high_rb), 24'h0);
      check(24'(lifted), 24'h0);
      check(vector_link_if_inst.vector_addr, 24'h008000);
      check(haddr, 24'h008000);
      check(24'(enter), 24'h0);
      see_irq(1'b0, 0, 0);
   endtask
   task automatic t_causes();
      for (int i = 0; i < 13; i++) begin
         src[LSB[i]] = 1'b1;
         tick(2);
         see_irq(1'b0, 0, 0);
         src[LSB[i]] = 1'b0;
         set_lvl(14 + i, 3);
         for (int b = 0; b < WID[i]; b++) begin
            src[LSB[i] + b] = 1'b1;
            tick(2);
            see_irq(1'b1, 14 + i, 3);
            src[LSB[i] + b] = 1'b0;
            tick(2);
            see_irq(1'b0, 0, 0);
         end
      end
   endtask
   task automatic t_base();
      wbase(1'b0, 16'h1234);
      check(24'(low_rb), 24'h008000);
      set_key(16'h0096);
      check(24'(lifted), 24'h1);
      wbase(1'b0, 16'h12ab);
      wbase(1'b1, 16'hff45);
      check(24'(low_rb), 24'h001200);
      check(24'(high_rb), 24'h000045);
      set_key(16'h0097);
      check(24'(lifted), 24'h0);
      wbase(1'b1, 16'h0077);
      check(24'(high_rb), 24'h000045);
      base = 24'h451200;
      src[29] = 1'b1;
      tick(2);
      see_irq(1'b1, 22, 3);
      src[29] = 1'b0;
      tick(2);
   endtask
   task automatic t_prio();
      set_lvl(14, 2);
      set_lvl(16, 5);
      set_lvl(25, 5);
      src[0] = 1'b1;
      src[35] = 1'b1;
      src[8] = 1'b1;
      tick(2);
      see_irq(1'b1, 16, 5);
      pulse(en_i);
      accept(16, 5);
      src[8] = 1'b0;
      tick(2);
      see_irq(1'b1, 25, 5);
      check(24'(ie), 24'h0);
      pulse(ret_i);
      accept(25, 5);
      src[35] = 1'b0;
      pulse(ret_i);
      accept(14, 2);
      src[0] = 1'b0;
      pulse(ret_i);
      pulse(dis_i);
      check(24'(ie), 24'h0);
      tick(2);
      see_irq(1'b0, 0, 0);
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end
      else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      tick(20);
      reset_n_in = 1'b1;
      tick(2);
      t_reset();
      t_causes();
      t_base();
      t_prio();
      give_verdict();
   end
   // the whole run needs well under a thousand cycles; this allows twenty thousand
   initial begin
      #100000;
      failures++;
      give_verdict();
   end
endmodule // interrupt_vector_table_base_tb
`default_nettype wire
